// >>> acs_pkg.sv
// What this block does
// - Three channel bits select multiplexer input, MSB first
// - Channel load starts settle pulse; blocks conversion
// - Software start converts when settle pulse expires
// - Convert bit acts after sixth serial clock
// - Convert bit set disables hardware start pin
// - Stored convert bit never repeats conversions
// - Standby bit enters or leaves power-down
// - Standby taken on seventh falling serial edge
// - Start pin rise converts only after settling
// - Settle pin drops low when write begins
// - Settle discharge begins at sixth falling edge
// - Tracking held until capacitor threshold crossed
// - Conversion completes 5.9 us after start
// - Writes under six clocks leave control register unchanged
// - Convert bit set starts conversion in any frame of four or more clocks
// - Control register resets to all zeros
package acs_pkg;
	localparam int CTRL_W = 5;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 5'h00;
	localparam int CHAN_MSB = 4;
	localparam int CHAN_LSB = 2;
	localparam int START_POS = 1;
	localparam int PDOWN_POS = 0;
	localparam logic [2:0] CNT_START = 3'h4;
	localparam logic [2:0] CNT_LOAD = 3'h6;
	localparam logic [2:0] CNT_PDOWN = 3'h7;
	localparam int CLK_PERIOD_PS = 10000;
	localparam int SOFT_CONVERT_BIT_TIME_PS = 5900000;
	localparam int SOFT_CONVERT_BIT_CYCLES = SOFT_CONVERT_BIT_TIME_PS / CLK_PERIOD_PS;
	localparam int SOFT_CONVERT_BIT_CLK_EDGES = 15;
	typedef enum logic [2:0] {
		ACS_TRACK = 3'b001,
		ACS_CONVERT = 3'b010,
		ACS_SLEEP = 3'b100
	} acs_state_t;
endpackage

// >>> acs_sync.sv
`timescale 1ns/1ps
// Two-flop synchroniser per bit
module acs_sync #(
	parameter int W = 1
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta;
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			always_ff @(posedge clock) begin
				if (!rst_n) begin
					meta[i] <= 1'b1;
					q[i] <= 1'b1;
				end else begin
					meta[i] <= d[i];
					q[i] <= meta[i];
				end
			end
		end
	endgenerate
endmodule

// >>> acs_control.sv
`timescale 1ns/1ps
module acs_control
	import acs_pkg::*;
#(
	parameter int SOFT_CONVERT_BIT_COUNT = SOFT_CONVERT_BIT_CYCLES
) (
	input wire logic clock,
	input wire logic rst_n,
	input wire logic sclk,
	input wire logic sdata,
	input wire logic transmit_frame_n,
	input wire logic hw_start_n,
	input wire logic soft_convert_bit_clk_in,
	input wire logic settle_cap_above,
	output logic settle_timing_cap,
	output logic [2:0] mux_sel,
	output logic hold,
	output logic converting,
	output logic soft_convert_bit_done,
	output logic powerdown
);
	// ---------------------------------------------------------------
	// Input synchronisation
	// ---------------------------------------------------------------
	logic [5:0] raw;
	logic [5:0] s;
	logic sclk_s, sdata_s, frame_n_s, start_n_s, cclk_s, cap_s;
	assign raw = {sclk, sdata, transmit_frame_n, hw_start_n, soft_convert_bit_clk_in, settle_cap_above};
	acs_sync #(.W(6)) u_sync (
		.clock(clock),
		.rst_n(rst_n),
		.d(raw),
		.q(s)
	);
	assign {sclk_s, sdata_s, frame_n_s, start_n_s, cclk_s, cap_s} = s;
	logic sclk_d, frame_d, start_d, cclk_d;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			sclk_d <= 1'b1;
			frame_d <= 1'b1;
			start_d <= 1'b1;
			cclk_d <= 1'b1;
		end else begin
			sclk_d <= sclk_s;
			frame_d <= frame_n_s;
			start_d <= start_n_s;
			cclk_d <= cclk_s;
		end
	end
	logic sclk_fall, frame_start, frame_end, start_rise, cclk_rise;
	assign sclk_fall = sclk_d && !sclk_s;
	assign frame_start = frame_d && !frame_n_s;
	assign frame_end = !frame_d && frame_n_s;
	assign start_rise = !start_d && start_n_s;
	assign cclk_rise = !cclk_d && cclk_s;

	// ---------------------------------------------------------------
	// Serial control word
	// ---------------------------------------------------------------
	acs_state_t state;
	logic [CTRL_W-1:0] shift;
	logic [2:0] bit_cnt;
	logic load_evt, pdown_evt;
	assign load_evt = sclk_fall && !frame_n_s && bit_cnt == CNT_LOAD - 3'h1;
	assign pdown_evt = sclk_fall && !frame_n_s && bit_cnt == CNT_PDOWN - 3'h1;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			shift <= CTRL_RESET;
			bit_cnt <= 3'h0;
		end else if (frame_start) begin
			bit_cnt <= 3'h0;
		end else if (sclk_fall && !frame_n_s && bit_cnt != CNT_PDOWN) begin
			shift <= {shift[CTRL_W-2:0], sdata_s};
			bit_cnt <= bit_cnt + 3'h1;
		end
	end
	// Sampled data arrives on falling edges; the fifth bit is in after edge five,
	// the word commits at edge six so shorter frames leave it untouched.
	logic [CTRL_W-1:0] ctrl;
	logic soft_convert_bit_req;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ctrl <= CTRL_RESET;
		end else if (load_evt) begin
			ctrl[CHAN_MSB:START_POS] <= shift[CHAN_MSB:START_POS];
		end else if (pdown_evt) begin
			// The sixth bit has pushed the standby bit one place up
			ctrl[PDOWN_POS] <= shift[PDOWN_POS + 1];
		end
	end
	assign mux_sel = ctrl[CHAN_MSB:CHAN_LSB];
	// Convert request latched by an aborted frame too, once its bit is shifted;
	// after four bits it is the newest, after five it sits one place up
	logic short_soft_convert_bit;
	assign short_soft_convert_bit = frame_end && (
		(bit_cnt == CNT_START && shift[START_POS - 1]) ||
		(bit_cnt == CNT_LOAD - 3'h1 && shift[START_POS]));
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			soft_convert_bit_req <= 1'b0;
		end else if (load_evt) begin
			soft_convert_bit_req <= shift[START_POS];
		end else if (short_soft_convert_bit) begin
			soft_convert_bit_req <= 1'b1;
		end else if (state == ACS_CONVERT) begin
			soft_convert_bit_req <= 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Settling pulse
	// ---------------------------------------------------------------
	logic discharging;
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			settle_timing_cap <= 1'b1;
			discharging <= 1'b0;
		end else if (frame_start) begin
			settle_timing_cap <= 1'b0;
			discharging <= 1'b0;
		end else if (load_evt || short_soft_convert_bit) begin
			settle_timing_cap <= 1'b1;
			discharging <= 1'b1;
		end else if (discharging && cap_s) begin
			discharging <= 1'b0;
		end
	end
	logic settled;
	assign settled = !discharging && frame_n_s && settle_timing_cap;

	// ---------------------------------------------------------------
	// Conversion sequencer
	// ---------------------------------------------------------------
	logic [15:0] soft_convert_bit_cnt;
	logic [4:0] cclk_cnt;
	logic go;
	assign go = settled && ((soft_convert_bit_req) || (!ctrl[START_POS] && start_rise));
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state <= ACS_TRACK;
			soft_convert_bit_cnt <= 16'h0000;
			cclk_cnt <= 5'h00;
			soft_convert_bit_done <= 1'b0;
		end else begin
			soft_convert_bit_done <= 1'b0;
			case (state)
				ACS_TRACK: begin
					if (ctrl[PDOWN_POS]) begin
						state <= ACS_SLEEP;
					end else if (go) begin
						state <= ACS_CONVERT;
						soft_convert_bit_cnt <= 16'h0000;
						cclk_cnt <= 5'h00;
					end
				end
				ACS_CONVERT: begin
					soft_convert_bit_cnt <= soft_convert_bit_cnt + 16'h0001;
					if (cclk_rise) begin
						cclk_cnt <= cclk_cnt + 5'h01;
					end
					if (soft_convert_bit_cnt == 16'(SOFT_CONVERT_BIT_COUNT - 1)) begin
						state <= ACS_TRACK;
						soft_convert_bit_done <= 1'b1;
					end
				end
				ACS_SLEEP: begin
					if (!ctrl[PDOWN_POS]) begin
						state <= ACS_TRACK;
					end
				end
				default: state <= ACS_TRACK;
			endcase
		end
	end
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hold <= 1'b0;
			converting <= 1'b0;
			powerdown <= 1'b0;
		end else begin
			hold <= (state == ACS_TRACK && !ctrl[PDOWN_POS] && go) ||
				(state == ACS_CONVERT && soft_convert_bit_cnt != 16'(SOFT_CONVERT_BIT_COUNT - 1));
			converting <= hold;
			powerdown <= ctrl[PDOWN_POS] || state == ACS_SLEEP;
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	sequence soft_convert_bit_start_s;
		state == ACS_TRACK && go && !ctrl[PDOWN_POS];
	endsequence
	no_early_soft_convert_bit_a: assert property (@(posedge clock) disable iff (!rst_n)
		soft_convert_bit_start_s |-> settle_timing_cap && !discharging)
		else $error("conversion started during settling");
	hw_blocked_a: assert property (@(posedge clock) disable iff (!rst_n)
		(state == ACS_TRACK && start_rise && ctrl[START_POS] && !soft_convert_bit_req) |=> state != ACS_CONVERT)
		else $error("hardware start accepted while convert bit set");
	soft_convert_bit_len_a: assert property (@(posedge clock) disable iff (!rst_n)
		soft_convert_bit_start_s |=> (state == ACS_CONVERT) [*8])
		else $error("conversion ended too early");
	settle_low_a: assert property (@(posedge clock) disable iff (!rst_n)
		frame_start |=> !settle_timing_cap)
		else $error("settle pin not low at frame start");
	short_discard_a: assert property (@(posedge clock) disable iff (!rst_n)
		frame_end && bit_cnt < 3'h5 |=> $stable(ctrl))
		else $error("short write changed control");
	reset_zero_a: assert property (@(posedge clock)
		!rst_n |=> ctrl == CTRL_RESET)
		else $error("control not zero after reset");
	sleep_a: assert property (@(posedge clock) disable iff (!rst_n)
		ctrl[PDOWN_POS] |=> ##1 powerdown)
		else $error("standby not entered");
	one_shot_a: assert property (@(posedge clock) disable iff (!rst_n)
		soft_convert_bit_done |=> !soft_convert_bit_req || $past(load_evt) || $past(short_soft_convert_bit))
		else $error("convert bit repeated conversion");
endmodule

// >>> acs_host.sv
`timescale 1ns/1ps
// ----------------------------------------
// Host serial port model
// ----------------------------------------
module acs_host (
	output logic sclk,
	output logic sdata,
	output logic transmit_frame_n
);
	initial begin
		sclk = 1'b1;
		sdata = 1'b0;
		transmit_frame_n = 1'b1;
	end
	// Clock stands high between frames; released data line flips so stale bits never match
	task automatic send(input logic [4:0] word, input int n);
		logic [6:0] bits;
		bits = {word, word[0], 1'b0};
		transmit_frame_n = 1'b0;
		#62.5;
		for (int i = 6; i > 6 - n; i--) begin
			sdata = bits[i];
			#62.5 sclk = 1'b0;
			#62.5 sclk = 1'b1;
		end
		#62.5 transmit_frame_n = 1'b1;
		sdata = ~sdata;
	endtask
endmodule

// >>> tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import acs_pkg::*;
	localparam int SOFT_CONVERT_BIT = 20;
	// Start-to-start spacing stays below the slowest allowed throughput
	localparam int GAP = 1290;
	logic clock, rst_n, hw_start_n, soft_convert_bit_clk_in, settle_cap_above;
	logic sclk, sdata, transmit_frame_n;
	logic settle_timing_cap, hold, converting, soft_convert_bit_done, powerdown;
	logic [2:0] mux_sel;
	int fail_count = 0;
	int num_checks = 0;
	int cycles = 0;
	acs_host host (.sclk(sclk), .sdata(sdata), .transmit_frame_n(transmit_frame_n));
	acs_control #(.SOFT_CONVERT_BIT_COUNT(SOFT_CONVERT_BIT)) dut (.clock(clock), .rst_n(rst_n), .sclk(sclk),
		.sdata(sdata), .transmit_frame_n(transmit_frame_n), .hw_start_n(hw_start_n),
		.soft_convert_bit_clk_in(soft_convert_bit_clk_in), .settle_cap_above(settle_cap_above),
		.settle_timing_cap(settle_timing_cap), .mux_sel(mux_sel), .hold(hold),
		.converting(converting), .soft_convert_bit_done(soft_convert_bit_done), .powerdown(powerdown));
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	initial begin
		soft_convert_bit_clk_in = 1'b0;
		forever #200 soft_convert_bit_clk_in = ~soft_convert_bit_clk_in;
	end
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Capacitor comparator drops with the frame and stays low until settle()
	task automatic wr(input logic [4:0] w, input int n);
		settle_cap_above = 1'b0;
		host.send(w, n);
	endtask
	task automatic settle();
		repeat (5) @(negedge clock);
		chk("settle_pin", settle_timing_cap, 1'b1);
		settle_cap_above = 1'b1;
	endtask
	task automatic hw_pulse();
		hw_start_n = 1'b0;
		repeat (6) @(negedge clock);
		hw_start_n = 1'b1;
	endtask
	// Gap after each conversion keeps the host out of the acquisition window
	// and paces starts at a rate both clocking modes can sustain
	task automatic expect_soft_convert_bit(input logic e);
		int n;
		n = 0;
		while (hold !== 1'b1 && n < 12) begin
			@(negedge clock);
			n++;
		end
		chk("hold", hold, e);
		n = 0;
		while (hold === 1'b1 && n < 100) begin
			@(negedge clock);
			n++;
		end
		if (e) chk("soft_convert_bit_len", 8'(n), 8'(SOFT_CONVERT_BIT));
		chk("soft_convert_bit_done", soft_convert_bit_done, e);
		chk("converting", converting, e);
		repeat (GAP) @(negedge clock);
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 30000) begin
			fail_count++;
			wrap_up();
		end
	end
	// ----------------------------------------
	// Tests
	// ----------------------------------------
	initial begin
		rst_n = 1'b0;
		hw_start_n = 1'b1;
		settle_cap_above = 1'b1;
		repeat (4) @(negedge clock);
		rst_n = 1'b1;
		chk("mux_sel", mux_sel, 3'h0);
		chk("powerdown", powerdown, 1'b0);
		chk("settle_pin", settle_timing_cap, 1'b1);
		repeat (3) @(negedge clock);
		for (int c = 0; c < 8; c++) begin
			fork
				wr({c[2:0], 2'b00}, 6);
				begin
					repeat (20) @(negedge clock);
					chk("settle_pin", settle_timing_cap, 1'b0);
				end
			join
			settle();
			chk("mux_sel", mux_sel, c[2:0]);
		end
		$display("test channel select done");
		wr(5'h14, 6);
		hw_pulse();
		expect_soft_convert_bit(1'b0);
		settle();
		hw_pulse();
		expect_soft_convert_bit(1'b1);
		$display("test hardware start done");
		wr(5'h0a, 6);
		expect_soft_convert_bit(1'b0);
		settle();
		expect_soft_convert_bit(1'b1);
		expect_soft_convert_bit(1'b0);
		hw_pulse();
		expect_soft_convert_bit(1'b0);
		wr(5'h08, 6);
		settle();
		hw_pulse();
		expect_soft_convert_bit(1'b1);
		$display("test software start done");
		wr(5'h1c, 4);
		settle_cap_above = 1'b1;
		repeat (10) @(negedge clock);
		chk("mux_sel", mux_sel, 3'h2);
		wr(5'h1a, 5);
		settle_cap_above = 1'b1;
		expect_soft_convert_bit(1'b1);
		wr(5'h1a, 4);
		settle_cap_above = 1'b1;
		expect_soft_convert_bit(1'b1);
		$display("test short frame done");
		wr(5'h09, 6);
		settle();
		chk("powerdown", powerdown, 1'b0);
		wr(5'h09, 7);
		settle();
		chk("powerdown", powerdown, 1'b1);
		wr(5'h08, 7);
		settle();
		chk("powerdown", powerdown, 1'b0);
		$display("test standby done");
		wrap_up();
	end
endmodule
